// [src/clock_output_pin_pkg.sv]
// Contract
// - The bus-stop clock-off delay is used only while the delayed clock-off enable bit is one.
// - The clock-off delay is 1.4 ms when the delay select bit is zero (default) and 75 ms when one.
// - The interrupt-delay enable bit (default zero, no delay) holds interrupts back 1/256 to 3/512 s after clock-on.
// - The interrupt delay applies only when the clock is not directly enabled, and only to clock-masked sources.
// - The event-input clock mask bit, default zero, selects the event-input interrupt as a clock-on source.
// - The alarm clock mask bit at position 4, default zero, selects the alarm interrupt as a clock-on source.
// - The countdown clock mask bit, default zero, selects the countdown timer interrupt as a clock-on source.
// - The update clock mask bit, default zero, selects the periodic update interrupt as a clock-on source.
package clock_output_pin_pkg;

  localparam int CLK_PERIOD_NS = 20;
  localparam int OFF_SHORT_NS  = 1400000;
  localparam int OFF_LONG_NS   = 75000000;
  localparam int IRQ_DELAY_NS  = 3906250;
  localparam int OFF_SHORT_CYC = OFF_SHORT_NS / CLK_PERIOD_NS;
  localparam int OFF_LONG_CYC  = OFF_LONG_NS / CLK_PERIOD_NS;
  localparam int IRQ_DELAY_CYC = (IRQ_DELAY_NS + CLK_PERIOD_NS - 1) /
                                 CLK_PERIOD_NS;
  localparam int TMR_W         = 22;

  localparam logic [4:0] OFS_CLKMASK = 5'h00;
  localparam logic [4:0] OFS_CTRL    = 5'h04;
  localparam logic [4:0] OFS_STATUS  = 5'h08;
  localparam logic [4:0] OFS_IRQMASK = 5'h0c;
  localparam logic [4:0] OFS_STATE   = 5'h10;

  localparam int MASK_EVT_BIT = 5;
  localparam int MASK_ALM_BIT = 4;
  localparam int MASK_CNT_BIT = 3;
  localparam int MASK_UPD_BIT = 2;

  localparam int CTRL_OFFDLY_EN_BIT  = 0;
  localparam int CTRL_OFFDLY_SEL_BIT = 1;
  localparam int CTRL_IRQDLY_EN_BIT  = 2;
  localparam int CTRL_NOT_DIRECT_BIT = 3;

  localparam int ST_CLK_ON_BIT  = 0;
  localparam int ST_CLK_OFF_BIT = 1;
  localparam int ST_INT_BIT     = 2;
  localparam int NUM_EVENTS     = 3;

  localparam logic [7:0] CLKMASK_RST = 8'h00;
  localparam logic [3:0] CTRL_RST    = 4'h0;
  localparam logic [2:0] IRQMASK_RST = 3'h0;

endpackage

// [src/delay_timer_if.sv]
`timescale 1ns/100ps
interface delay_timer_if #(parameter int W = 22);
  logic         start;
  logic [W-1:0] load;
  logic         busy;
  modport ctrl (output start, output load, input busy);
  modport tmr  (input start, input load, output busy);
endinterface

// [src/delay_timer.sv]
`timescale 1ns/100ps
module delay_timer #(
  parameter int W = 22
) (
  input  wire logic   clk_in,   // System clock.
  input  wire logic   rst_n_in, // Synchronised reset, active low.
  delay_timer_if.tmr  t_if      // Start, load and busy.
);
  logic [W-1:0] count_r;

  // A start restarts the count even while one is running.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_r <= '0;
    end else if (t_if.start) begin
      count_r <= t_if.load;
    end else if (count_r != '0) begin
      count_r <= count_r - 1'b1;
    end
  end

  assign t_if.busy = (count_r != '0);
endmodule

// [src/irq_status.sv]
`timescale 1ns/100ps
module irq_status #(
  parameter int N = 3
) (
  input  wire logic         clk_in,    // System clock.
  input  wire logic         rst_n_in,  // Synchronised reset, active low.
  input  wire logic [N-1:0] event_in,  // One-cycle event pulses.
  input  wire logic [N-1:0] mask_in,   // Interrupt enables.
  input  wire logic         clear_in,  // Status read in its stall cycle.
  output logic      [N-1:0] status_out,// Sticky status bits.
  output logic              irq_out    // Level interrupt.
);
  // An event in the clearing cycle survives: set wins over clear.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_out <= '0;
    end else begin
      status_out <= (status_out & ~{N{clear_in}}) | event_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status_out & mask_in);
    end
  end
endmodule

// [src/clock_output_pin_ctrl.sv]
`timescale 1ns/100ps
module clock_output_pin_ctrl #(
  parameter int OFF_SHORT_CYC = clock_output_pin_pkg::OFF_SHORT_CYC,
  parameter int OFF_LONG_CYC  = clock_output_pin_pkg::OFF_LONG_CYC,
  parameter int IRQ_DELAY_CYC = clock_output_pin_pkg::IRQ_DELAY_CYC,
  parameter int TMR_W         = clock_output_pin_pkg::TMR_W
) (
  input  wire logic        clk_sys_in,              // 50 MHz clock.
  input  wire logic        rst_n_in,                // Async reset, low.
  input  wire logic [4:0]  avs_address_in,          // Byte address.
  input  wire logic        avs_read_in,             // Read request.
  input  wire logic        avs_write_in,            // Write request.
  input  wire logic [31:0] avs_writedata_in,        // Write data.
  input  wire logic [3:0]  avs_byteenable_in,       // Byte lanes.
  output logic      [31:0] avs_readdata_out,        // Read data.
  output logic             avs_waitrequest_out,     // Slave stall.
  input  wire logic        event_input_irq_signal_in, // Event irq.
  input  wire logic        alarm_irq_signal_in,     // Alarm irq.
  input  wire logic        countdown_irq_signal_in, // Countdown irq.
  input  wire logic        update_irq_signal_in,    // Update irq.
  input  wire logic        bus_stop_in,             // Bus stop pulse.
  input  wire logic        clock_source_in,         // Clock to gate.
  output logic             clock_output_pin_out,    // Gated clock.
  output logic             int_pin_out,             // Device interrupt.
  output logic             irq_out                  // Block interrupt.
);

  typedef enum logic [2:0] {
    CK_OFF  = 3'h1,
    CK_ON   = 3'h2,
    CK_HOLD = 3'h4
  } clk_state_type;

  logic               rst_meta_r;
  logic               rst_sync_r;
  logic               rst_n;
  logic               ack_r;
  logic               access;
  logic               accept;
  logic               wr_en;
  logic               rd_status;
  logic [31:0]        rd_nxt;
  logic [7:0]         clkmask_r;
  logic [3:0]         ctrl_r;
  logic [2:0]         irqmask_r;
  logic [3:0]         src;
  logic [3:0]         clk_mask_vec;
  logic [3:0]         sel;
  logic               any_sel;
  logic               direct_on;
  logic               need_on;
  logic               hold_start;
  logic               hold_run;
  logic               irq_dly_apply;
  clk_state_type      state_r;
  clk_state_type      state_nxt;
  logic               clk_on;
  logic               clk_on_nxt;
  logic               turn_on;
  logic               turn_off;
  logic               delay_ok_r;
  logic               int_nxt;
  logic               int_rise;
  logic [2:0]         events;
  logic [2:0]         status;

  delay_timer_if #(.W(TMR_W)) hold_if ();
  delay_timer_if #(.W(TMR_W)) idly_if ();

  // Reset is asserted at once but released only after two edges.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign rst_n = rst_sync_r;

  // Every access stalls exactly one cycle so read data can settle.
  assign access              = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = access & ~ack_r;
  assign accept              = access & ack_r;
  assign wr_en     = avs_write_in & accept & avs_byteenable_in[0];
  // Status clears at the stall edge, where the reported copy is taken,
  // so an event landing on that same edge is kept for the next read.
  assign rd_status = avs_read_in & ~ack_r &
                     (avs_address_in == clock_output_pin_pkg::OFS_STATUS);

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= access & ~ack_r;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      clkmask_r <= clock_output_pin_pkg::CLKMASK_RST;
    end else if (wr_en &&
                 avs_address_in == clock_output_pin_pkg::OFS_CLKMASK) begin
      clkmask_r <= avs_writedata_in[7:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= clock_output_pin_pkg::CTRL_RST;
    end else if (wr_en && avs_address_in == clock_output_pin_pkg::OFS_CTRL) begin
      ctrl_r <= avs_writedata_in[3:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      irqmask_r <= clock_output_pin_pkg::IRQMASK_RST;
    end else if (wr_en &&
                 avs_address_in == clock_output_pin_pkg::OFS_IRQMASK) begin
      irqmask_r <= avs_writedata_in[2:0];
    end
  end

  // Unmapped addresses read as zero; writes to them are dropped.
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (avs_address_in)
      clock_output_pin_pkg::OFS_CLKMASK: rd_nxt[7:0] = clkmask_r;
      clock_output_pin_pkg::OFS_CTRL:    rd_nxt[3:0] = ctrl_r;
      clock_output_pin_pkg::OFS_STATUS:  rd_nxt[2:0] = status;
      clock_output_pin_pkg::OFS_IRQMASK: rd_nxt[2:0] = irqmask_r;
      clock_output_pin_pkg::OFS_STATE: begin
        rd_nxt[0]   = clk_on;
        rd_nxt[1]   = hold_if.busy;
        rd_nxt[2]   = idly_if.busy;
        rd_nxt[3]   = int_pin_out;
        rd_nxt[7:4] = src;
      end
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // Captured in the stall cycle, so it stands at the accepting edge.
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && !ack_r) begin
      avs_readdata_out <= rd_nxt;
    end
  end

  assign src = {event_input_irq_signal_in, alarm_irq_signal_in,
                countdown_irq_signal_in, update_irq_signal_in};

  assign clk_mask_vec[3] = clkmask_r[clock_output_pin_pkg::MASK_EVT_BIT];
  assign clk_mask_vec[2] = clkmask_r[clock_output_pin_pkg::MASK_ALM_BIT];
  assign clk_mask_vec[1] = clkmask_r[clock_output_pin_pkg::MASK_CNT_BIT];
  assign clk_mask_vec[0] = clkmask_r[clock_output_pin_pkg::MASK_UPD_BIT];

  assign sel     = src & clk_mask_vec;
  assign any_sel = |sel;

  // With the not-direct bit clear the clock simply runs all the time.
  assign direct_on = ~ctrl_r[clock_output_pin_pkg::CTRL_NOT_DIRECT_BIT];
  assign need_on   = direct_on | any_sel;

  // A stop only arms the hold while the delayed clock-off is enabled.
  assign hold_start = bus_stop_in &
                      ctrl_r[clock_output_pin_pkg::CTRL_OFFDLY_EN_BIT];

  // Clearing the enable mid-hold lets the clock stop without waiting.
  assign hold_run = hold_if.busy &
                    ctrl_r[clock_output_pin_pkg::CTRL_OFFDLY_EN_BIT];

  assign hold_if.start = hold_start;
  assign hold_if.load  = ctrl_r[clock_output_pin_pkg::CTRL_OFFDLY_SEL_BIT] ?
                         TMR_W'(OFF_LONG_CYC) :
                         TMR_W'(OFF_SHORT_CYC);

  delay_timer #(.W(TMR_W)) u_hold_timer (
    .clk_in   (clk_sys_in),
    .rst_n_in (rst_n),
    .t_if     (hold_if.tmr)
  );

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CK_OFF: begin
        if (need_on) begin
          state_nxt = CK_ON;
        end else if (hold_start) begin
          state_nxt = CK_HOLD;
        end
      end
      CK_ON: begin
        if (!need_on) begin
          state_nxt = (hold_run || hold_start) ? CK_HOLD : CK_OFF;
        end
      end
      CK_HOLD: begin
        if (need_on) begin
          state_nxt = CK_ON;
        end else if (!hold_run && !hold_start) begin
          state_nxt = CK_OFF;
        end
      end
      default: state_nxt = CK_OFF;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= CK_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign clk_on     = (state_r != CK_OFF);
  assign clk_on_nxt = (state_nxt != CK_OFF);
  assign turn_on    = clk_on_nxt & ~clk_on;
  assign turn_off   = clk_on & ~clk_on_nxt;

  // The source is resampled, so the pin tops out at half the clock.
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      clock_output_pin_out <= 1'b0;
    end else begin
      clock_output_pin_out <= clk_on & clock_source_in;
    end
  end

  assign irq_dly_apply = ctrl_r[clock_output_pin_pkg::CTRL_IRQDLY_EN_BIT] &
                         ctrl_r[clock_output_pin_pkg::CTRL_NOT_DIRECT_BIT];

  // The lower bound of the window is used so the pin is never late.
  assign idly_if.start = turn_on;
  assign idly_if.load  = TMR_W'(IRQ_DELAY_CYC);

  delay_timer #(.W(TMR_W)) u_irq_timer (
    .clk_in   (clk_sys_in),
    .rst_n_in (rst_n),
    .t_if     (idly_if.tmr)
  );

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      delay_ok_r <= 1'b0;
    end else begin
      delay_ok_r <= clk_on & ~idly_if.busy & ~turn_on;
    end
  end

  // Only clock-masked sources wait; the others pass straight on.
  assign int_nxt = (|(src & ~clk_mask_vec)) |
                   (any_sel & (~irq_dly_apply | delay_ok_r));

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      int_pin_out <= 1'b0;
    end else begin
      int_pin_out <= int_nxt;
    end
  end

  assign int_rise = int_nxt & ~int_pin_out;

  assign events[clock_output_pin_pkg::ST_CLK_ON_BIT]  = turn_on;
  assign events[clock_output_pin_pkg::ST_CLK_OFF_BIT] = turn_off;
  assign events[clock_output_pin_pkg::ST_INT_BIT]     = int_rise;

  irq_status #(.N(clock_output_pin_pkg::NUM_EVENTS)) u_irq_status (
    .clk_in     (clk_sys_in),
    .rst_n_in   (rst_n),
    .event_in   (events),
    .mask_in    (irqmask_r),
    .clear_in   (rd_status),
    .status_out (status),
    .irq_out    (irq_out)
  );

endmodule

// [test/clk_sink.sv]
`timescale 1ns/100ps
module clk_sink (
  input  wire logic        clk_sys_in, // Sampling clock.
  input  wire logic        rst_n_in,   // Reset, active low.
  input  wire logic        pin_in,     // Gated clock from the block.
  output logic      [15:0] edges_out   // Rising edges seen so far.
);
  logic last_r;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      last_r    <= 1'b0;
      edges_out <= 16'h0;
    end else begin
      last_r <= pin_in;
      if (pin_in && !last_r) begin
        edges_out <= edges_out + 16'h1;
      end
    end
  end
endmodule

// [test/clock_output_pin_ctrl_asserts.sv]
`timescale 1ns/100ps
module clock_output_pin_ctrl_asserts (
  input wire logic        clk_sys_in, rst_n_in,       // Clock, reset.
  input wire logic [4:0]  avs_address_in,             // Byte address.
  input wire logic        avs_read_in, avs_write_in,  // Requests.
  input wire logic [31:0] avs_writedata_in,           // Write data.
  input wire logic [3:0]  avs_byteenable_in,          // Byte lanes.
  input wire logic [31:0] avs_readdata_out,           // Read data.
  input wire logic        avs_waitrequest_out,        // Stall.
  input wire logic        event_input_irq_signal_in,  // Sources.
  input wire logic        alarm_irq_signal_in, countdown_irq_signal_in,
  input wire logic        update_irq_signal_in, bus_stop_in,
  input wire logic        clock_source_in, clock_output_pin_out,
  input wire logic        int_pin_out                 // Interrupt pin.
);
  logic [2:0] live_r;
  logic [7:0] mask_r;
  logic [3:0] ctrl_r;
  logic [3:0] src;
  logic       need;
  logic       apply;
  assign src = {event_input_irq_signal_in, alarm_irq_signal_in,
                countdown_irq_signal_in, update_irq_signal_in};
  assign need = !ctrl_r[3] || |(src & mask_r[5:2]);
  assign apply = ctrl_r[2] && ctrl_r[3];
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!live_r[2]);
  // The block leaves reset two edges after the pin, so checks wait three.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      live_r <= 3'h0;
    end else begin
      live_r <= {live_r[1:0], 1'b1};
    end
  end
  // Shadow copies of what software wrote, taken at the accepting edge.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mask_r <= 8'h00;
      ctrl_r <= 4'h0;
    end else if (avs_write_in && !avs_waitrequest_out &&
                 avs_byteenable_in[0]) begin
      if (avs_address_in == clock_output_pin_pkg::OFS_CLKMASK) begin
        mask_r <= avs_writedata_in[7:0];
      end
      if (avs_address_in == clock_output_pin_pkg::OFS_CTRL) begin
        ctrl_r <= avs_writedata_in[3:0];
      end
    end
  end
  wait_rise_a: assert property ($rose(avs_read_in || avs_write_in)
    |-> avs_waitrequest_out) else $error("no stall on new request");
  wait_one_a: assert property ((avs_read_in || avs_write_in) &&
    avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("stall longer than one cycle");
  unmapped_zero_a: assert property (avs_read_in && !avs_waitrequest_out
    && avs_address_in > 5'h10 |-> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
  pin_on_a: assert property (need |=> ##1
    clock_output_pin_out == $past(clock_source_in))
    else $error("clock pin not following source");
  pin_off_a: assert property ((!ctrl_r[0] && !need) [*2]
    |=> !clock_output_pin_out) else $error("clock pin not stopped");
  hold_on_a: assert property (bus_stop_in && ctrl_r[0] |=> ##2
    (clock_output_pin_out == $past(clock_source_in)) [*8])
    else $error("clock dropped during hold");
  int_direct_a: assert property (|(src & ~mask_r[5:2]) |=> int_pin_out)
    else $error("unmasked source missed");
  int_nodelay_a: assert property (!apply && |(src & mask_r[5:2])
    |=> int_pin_out) else $error("interrupt delayed without option");
  int_held_a: assert property (
    apply && $rose(|(src & mask_r[5:2])) && !(|(src & ~mask_r[5:2]))
    |=> !int_pin_out [*4])
    else $error("interrupt not held back");
endmodule
bind clock_output_pin_ctrl clock_output_pin_ctrl_asserts u_chk (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out),
  .event_input_irq_signal_in(event_input_irq_signal_in),
  .alarm_irq_signal_in(alarm_irq_signal_in),
  .countdown_irq_signal_in(countdown_irq_signal_in),
  .update_irq_signal_in(update_irq_signal_in), .bus_stop_in(bus_stop_in),
  .clock_source_in(clock_source_in),
  .clock_output_pin_out(clock_output_pin_out), .int_pin_out(int_pin_out));

// [test/clock_output_pin_ctrl_test.sv]
`timescale 1ns/100ps
module clock_output_pin_ctrl_test;
  logic        clk_sys_in, rst_n_in, rd, wr, bstop, src;
  logic [4:0]  adr;
  logic [31:0] wd, rdat;
  logic [3:0]  irqs;
  wire  [31:0] rdo;
  wire  [15:0] edges;
  wire         wreq, pin, intp, irq;
  int          errors, tests_run, cyc, e;
  clock_output_pin_ctrl #(.OFF_SHORT_CYC(20), .OFF_LONG_CYC(50),
    .IRQ_DELAY_CYC(10)) u_dut (.clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdo), .avs_waitrequest_out(wreq),
    .event_input_irq_signal_in(irqs[3]), .alarm_irq_signal_in(irqs[2]),
    .countdown_irq_signal_in(irqs[1]), .update_irq_signal_in(irqs[0]),
    .bus_stop_in(bstop), .clock_source_in(src),
    .clock_output_pin_out(pin), .int_pin_out(intp), .irq_out(irq));
  clk_sink u_sink (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .pin_in(pin), .edges_out(edges));
  initial begin
    clk_sys_in = 0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  // The source clock toggles every cycle, so a running pin rises every
  // second cycle; the run is cut short after 5000 cycles.
  always @(posedge clk_sys_in) begin
    src <= ~src;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      end_of_test();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    adr <= a;
    wd <= {24'h0, d};
    wr <= w;
    rd <= !w;
    // Waitrequest and read data are seen as they stood at this edge.
    do @(posedge clk_sys_in); while (wreq !== 1'b0);
    rdat = rdo;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task span(input int n);
    int e0;
    e0 = edges;
    repeat (n) @(posedge clk_sys_in);
    e = edges - e0;
  endtask
  task t_defaults;
    bus(0, clock_output_pin_pkg::OFS_CLKMASK, 8'h00);
    chk(rdat, 32'h0);
    bus(0, clock_output_pin_pkg::OFS_CTRL, 8'h00);
    chk(rdat, 32'h0);
    bus(0, 5'h14, 8'h00);
    chk(rdat, 32'h0);
    span(10);
    chk(32'(e), 32'h5);
  endtask
  task t_sources;
    bus(1, clock_output_pin_pkg::OFS_CTRL, 8'h08);
    for (int i = 0; i < 4; i++) begin
      irqs <= 4'h1 << i;
      span(6);
      span(8);
      chk(32'(e), 32'h0);
      bus(1, clock_output_pin_pkg::OFS_CLKMASK, 8'h04 << i);
      span(4);
      span(10);
      chk(32'(e), 32'h5);
      irqs <= 4'h0;
      span(4);
      span(8);
      chk(32'(e), 32'h0);
    end
  endtask
  task t_hold;
    logic [7:0] c[3] = '{8'h09, 8'h0b, 8'h08};
    int n[3] = '{16, 40, 0};
    int w[3] = '{8, 14, 2};
    for (int k = 0; k < 3; k++) begin
      bus(1, clock_output_pin_pkg::OFS_CTRL, c[k]);
      // The event source is clock-masked, so the clock already runs at
      // the stop and, with the delayed clock-off enabled, the hold alone keeps it going once the source drops.
      irqs <= 4'h8;
      span(4);
      bstop <= 1'b1;
      @(posedge clk_sys_in);
      bstop <= 1'b0;
      irqs <= 4'h0;
      span(n[k]);
      chk(32'(e), 32'(n[k] / 2));
      span(w[k]);
      span(8);
      chk(32'(e), 32'h0);
    end
  endtask
  task t_irq;
    bus(0, clock_output_pin_pkg::OFS_STATUS, 8'h00);
    chk(32'(irq), 32'h0);
    bus(1, clock_output_pin_pkg::OFS_IRQMASK, 8'h01);
    irqs <= 4'h8;
    span(4);
    chk(32'(irq), 32'h1);
    bus(0, clock_output_pin_pkg::OFS_STATUS, 8'h00);
    chk(rdat & 32'h1, 32'h1);
    span(2);
    chk(32'(irq), 32'h0);
    irqs <= 4'h0;
    bus(1, clock_output_pin_pkg::OFS_CTRL, 8'h0c);
    span(4);
    // The alarm is not clock-masked, so it must pass at once.
    irqs <= 4'h4;
    span(2);
    chk(32'(intp), 32'h1);
    irqs <= 4'h8;
    span(4);
    chk(32'(intp), 32'h0);
    span(20);
    chk(32'(intp), 32'h1);
    bus(0, clock_output_pin_pkg::OFS_STATE, 8'h00);
    chk(rdat, 32'h89);
    irqs <= 4'h0;
    bus(1, clock_output_pin_pkg::OFS_CTRL, 8'h04);
    irqs <= 4'h8;
    span(2);
    chk(32'(intp), 32'h1);
  endtask
  task end_of_test;
    $display("checks=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    {rst_n_in, rd, wr, bstop, src, adr, wd, irqs} = '0;
    {errors, tests_run, cyc} = '0;
    repeat (5) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    t_defaults();
    t_sources();
    t_hold();
    t_irq();
    end_of_test();
  end
endmodule
